// ===== rtl/bdma_core.sv
// banked data memory with indirect ports, pointers and bank select behind axi4-lite
//
// Overview of operation
// - Data memory is 8-bit volatile RAM split into special function and general areas over two banks.
// - General storage sits at 60H..FFH in bank 0 and at 80H..FFH in bank 1.
// - Every general storage location can be read and written.
// - Special function registers are seen in every bank, except the eeprom control at 40H, bank 1 only.
// - The data memory address space starts at 00H.
// - An access to an indirect port goes to the location held in its paired pointer instead.
// - Port 0 reaches only bank 0; port 1 reaches the bank chosen by the bank select.
// - An indirect access aimed at a port address reads 00H and writes nothing.
// - Both pointers are real registers that can be read, written and modified.
// - Direct accesses always go to bank 0; bank 1 is reached only through port 1.
// - Bit 0 of the bank select register chooses bank 0 or bank 1.
// - Any reset returns the bank to 0, except a watchdog time-out reset in power down.
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
module bdma_core (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic                          wdt_pd_reset,
  input  wire logic [bdma_pkg::AXI_AW-1:0]   s_axi_awaddr,
  input  wire logic [2:0]                    s_axi_awprot,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [bdma_pkg::AXI_DW-1:0]   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [bdma_pkg::AXI_AW-1:0]   s_axi_araddr,
  input  wire logic [2:0]                    s_axi_arprot,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [bdma_pkg::AXI_DW-1:0]        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  output logic                               bank_sel,
  output logic [bdma_pkg::DM_DATA_W-1:0]     eeprom_ctrl_reg
);
  import bdma_pkg::*;

  // resolved target: {null, bank, addr}
  typedef struct packed {
    logic       nul;
    logic       bank;
    logic [7:0] addr;
  } bdma_tgt_type;
  logic [7:0]    ptr0_ff;
  logic [7:0]    ptr1_ff;
  logic          bank_ff;
  logic [7:0]    ectl_ff;
  bdma_chan_type wst_ff;
  bdma_chan_type rst_ff;
  logic          aw_held_ff;
  logic          w_held_ff;
  logic [AXI_AW-1:0] awaddr_ff;
  logic [7:0]    wdata_ff;
  logic          wlane0_ff;
  logic          awready_ff;
  logic          wready_ff;
  logic          bvalid_ff;
  logic [1:0]    bresp_ff;
  logic          arready_ff;
  logic          rvalid_ff;
  logic [AXI_DW-1:0] rdata_ff;
  logic [1:0]    rresp_ff;
  logic          wr_exec;
  logic          wr_mapped;
  bdma_tgt_type  wr_tgt;
  bdma_tgt_type  rd_tgt;
  logic          ram_we;
  logic [RAM_IDX_W-1:0] ram_waddr;
  logic [RAM_IDX_W-1:0] ram_raddr;
  logic [7:0]    ram_rdata;
  logic [7:0]    nxt_rd_byte;
  logic          rd_mapped;
  // an address in the bus window maps to a data memory location from 00H upward
  function automatic logic in_window(input logic [AXI_AW-1:0] a);
    return (a[AXI_AW-1:10] == '0);
  endfunction
  // turn a direct location into the location really touched
  function automatic bdma_tgt_type resolve(input logic [7:0] a, input logic [7:0] p0,
                                           input logic [7:0] p1, input logic bank);
    bdma_tgt_type t;
    t = '{nul: 1'b0, bank: 1'b0, addr: a};
    if (a == IDX_PORT0) begin
      t.addr = p0;
      t.bank = 1'b0;
    end else if (a == IDX_PORT1) begin
      t.addr = p1;
      t.bank = bank;
    end
    // a pointer aimed at a port has no storage behind it
    if ((a == IDX_PORT0 || a == IDX_PORT1) &&
        (t.addr == IDX_PORT0 || t.addr == IDX_PORT1)) begin
      t.nul = 1'b1;
    end
    return t;
  endfunction
  // storage index of a general location, bank 0 first then bank 1
  function automatic logic [RAM_IDX_W-1:0] gp_index(input bdma_tgt_type t);
    if (!t.bank) begin
      return RAM_IDX_W'(t.addr - GP0_FIRST);
    end
    return RAM_IDX_W'(GP0_WORDS) + RAM_IDX_W'(t.addr - GP1_FIRST);
  endfunction
  // whether a target is general storage in its bank
  function automatic logic is_gp(input bdma_tgt_type t);
    return t.bank ? (t.addr >= GP1_FIRST) : (t.addr >= GP0_FIRST);
  endfunction
  // write side resolution from the held address
  always_comb begin
    wr_mapped = in_window(awaddr_ff);
    wr_tgt    = resolve(awaddr_ff[9:2], ptr0_ff, ptr1_ff, bank_ff);
    wr_exec   = (wst_ff == CH_IDLE) && aw_held_ff && w_held_ff;
  end
  // only byte lane 0 carries data; a write without it changes nothing
  always_comb begin
    ram_we    = wr_exec && wr_mapped && wlane0_ff && !wr_tgt.nul && is_gp(wr_tgt);
    ram_waddr = gp_index(wr_tgt);
  end
  bdma_gp_ram #(
    .WORDS  (RAM_WORDS),
    .DATA_W (DM_DATA_W),
    .IDX_W  (RAM_IDX_W)
  ) u_ram (
    .aclk  (aclk),
    .we    (ram_we),
    .waddr (ram_waddr),
    .wdata (wdata_ff),
    .raddr (ram_raddr),
    .rdata (ram_rdata)
  );
  // read side resolution straight from the bus address at the handshake
  always_comb begin
    rd_mapped   = in_window(s_axi_araddr);
    rd_tgt      = resolve(s_axi_araddr[9:2], ptr0_ff, ptr1_ff, bank_ff);
    ram_raddr   = gp_index(rd_tgt);
    nxt_rd_byte = 8'h00;
    if (rd_mapped && !rd_tgt.nul) begin
      if (is_gp(rd_tgt)) begin
        nxt_rd_byte = ram_rdata;
      end else begin
        case (rd_tgt.addr)
          IDX_PTR0: nxt_rd_byte = ptr0_ff;
          IDX_PTR1: nxt_rd_byte = ptr1_ff;
          IDX_BANK: nxt_rd_byte = {7'h00, bank_ff};
          IDX_ECTL: nxt_rd_byte = rd_tgt.bank ? ectl_ff : 8'h00;
          default:  nxt_rd_byte = 8'h00;
        endcase
      end
    end
  end
  // pointer registers, writable through any bank or through a port
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ptr0_ff <= PTR_RST;
      ptr1_ff <= PTR_RST;
    end else if (wr_exec && wr_mapped && wlane0_ff && !wr_tgt.nul) begin
      if (wr_tgt.addr == IDX_PTR0) begin
        ptr0_ff <= wdata_ff;
      end
      if (wr_tgt.addr == IDX_PTR1) begin
        ptr1_ff <= wdata_ff;
      end
    end
  end
  // bank select survives a watchdog reset taken in power down
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      if (!wdt_pd_reset) begin
        bank_ff <= BANK_RST;
      end
    end else if (wr_exec && wr_mapped && wlane0_ff && !wr_tgt.nul &&
                 wr_tgt.addr == IDX_BANK) begin
      bank_ff <= wdata_ff[BANK_BIT];
    end
  end
  // eeprom control exists only in bank 1, so only port 1 reaches it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ectl_ff <= ECTL_RST;
    end else if (wr_exec && wr_mapped && wlane0_ff && !wr_tgt.nul &&
                 wr_tgt.addr == IDX_ECTL && wr_tgt.bank) begin
      ectl_ff <= wdata_ff;
    end
  end
  // write address and data are taken in either order and held until both are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      awaddr_ff  <= '0;
      wdata_ff   <= 8'h00;
      wlane0_ff  <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
    end else if (wst_ff == CH_IDLE) begin
      if (s_axi_awvalid && awready_ff) begin
        aw_held_ff <= 1'b1;
        awaddr_ff  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_ff) begin
        w_held_ff <= 1'b1;
        wdata_ff  <= s_axi_wdata[7:0];
        wlane0_ff <= s_axi_wstrb[0];
      end
      awready_ff <= !(aw_held_ff || (s_axi_awvalid && awready_ff)) && !wr_exec;
      wready_ff  <= !(w_held_ff || (s_axi_wvalid && wready_ff)) && !wr_exec;
      if (wr_exec) begin
        aw_held_ff <= 1'b0;
        w_held_ff  <= 1'b0;
      end
    end else begin
      // reopen both channels once the response has been taken
      awready_ff <= s_axi_bready;
      wready_ff  <= s_axi_bready;
    end
  end
  // write response: one per executed write, held until bready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wst_ff    <= CH_IDLE;
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end else begin
      case (wst_ff)
        CH_IDLE: begin
          if (wr_exec) begin
            wst_ff    <= CH_RESP;
            bvalid_ff <= 1'b1;
            bresp_ff  <= wr_mapped ? RESP_OKAY : RESP_DECERR;
          end
        end
        CH_RESP: begin
          if (s_axi_bready) begin
            wst_ff    <= CH_IDLE;
            bvalid_ff <= 1'b0;
          end
        end
        default: begin
          wst_ff    <= CH_IDLE;
          bvalid_ff <= 1'b0;
        end
      endcase
    end
  end
  // read channel: data registered at the address handshake, held until rready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_ff     <= CH_IDLE;
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= '0;
      rresp_ff   <= RESP_OKAY;
    end else begin
      case (rst_ff)
        CH_IDLE: begin
          arready_ff <= 1'b1;
          if (s_axi_arvalid && arready_ff) begin
            rst_ff     <= CH_RESP;
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b1;
            rdata_ff   <= {24'h000000, nxt_rd_byte};
            rresp_ff   <= rd_mapped ? RESP_OKAY : RESP_DECERR;
          end
        end
        CH_RESP: begin
          if (s_axi_rready) begin
            rst_ff     <= CH_IDLE;
            rvalid_ff  <= 1'b0;
            arready_ff <= 1'b1;
          end
        end
        default: begin
          rst_ff    <= CH_IDLE;
          rvalid_ff <= 1'b0;
        end
      endcase
    end
  end

  // outputs straight from flip-flops
  assign s_axi_awready   = awready_ff;
  assign s_axi_wready    = wready_ff;
  assign s_axi_bvalid    = bvalid_ff;
  assign s_axi_bresp     = bresp_ff;
  assign s_axi_arready   = arready_ff;
  assign s_axi_rvalid    = rvalid_ff;
  assign s_axi_rdata     = rdata_ff;
  assign s_axi_rresp     = rresp_ff;
  assign bank_sel        = bank_ff;
  assign eeprom_ctrl_reg = ectl_ff;

  // checks on the addressing and bus response behaviour
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic dir_gp_wr, p0_gp_wr, p1_b1_wr;
  assign dir_gp_wr = wr_exec && wr_mapped && wlane0_ff && awaddr_ff[9:2] >= GP0_FIRST;
  assign p0_gp_wr  = wr_exec && wr_mapped && wlane0_ff && awaddr_ff[9:2] == IDX_PORT0 &&
                     ptr0_ff >= GP0_FIRST;
  assign p1_b1_wr  = wr_exec && wr_mapped && wlane0_ff && awaddr_ff[9:2] == IDX_PORT1 &&
                     bank_ff && ptr1_ff >= GP1_FIRST;
  read_upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  direct_bank0_a: assert property (
    dir_gp_wr |-> ram_we && ram_waddr == 9'(awaddr_ff[9:2] - 8'h60))
    else $error("direct write left bank 0");
  port0_redirect_a: assert property (
    p0_gp_wr |-> ram_we && ram_waddr == 9'(ptr0_ff - 8'h60))
    else $error("port 0 write not redirected");
  port1_bank1_a: assert property (
    p1_b1_wr |-> ram_we && ram_waddr == 9'(ptr1_ff) + 9'h020)
    else $error("port 1 write missed bank 1");
  port_null_a: assert property (
    wr_exec && wr_tgt.nul |-> !ram_we ##1 $stable(ptr0_ff) && $stable(ptr1_ff))
    else $error("write through port to port had effect");
  bank_reset_a: assert property (disable iff (1'b0) !aresetn && !wdt_pd_reset |=> !bank_ff)
    else $error("bank not cleared by reset");
  bank_keep_a: assert property (
    disable iff (1'b0) !aresetn && wdt_pd_reset |=> $stable(bank_ff))
    else $error("bank lost on watchdog power-down reset");
  ectl_direct_a: assert property (
    wr_exec && awaddr_ff[9:2] == IDX_ECTL |=> $stable(ectl_ff))
    else $error("eeprom control written from bank 0");
  write_resp_a: assert property (
    wr_exec |=> s_axi_bvalid && s_axi_bresp == ($past(wr_mapped) ? RESP_OKAY : RESP_DECERR))
    else $error("write not answered");
  read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  port1_b1_c: cover property (p1_b1_wr);
  port0_rd_c: cover property (s_axi_arvalid && s_axi_arready && s_axi_araddr[9:2] == IDX_PORT0);
  bank_keep_c: cover property (disable iff (1'b0) !aresetn && wdt_pd_reset && bank_ff);
endmodule // bdma_core

// ===== rtl/bdma_pkg.sv
// constants and types shared by the banked data memory addressing block
package bdma_pkg;
  // data memory geometry
  localparam int          DM_DATA_W      = 8;
  localparam int          DM_ADDR_W      = 8;
  localparam int          GP0_WORDS      = 160;   // 60H..FFH in bank 0
  localparam int          GP1_WORDS      = 128;   // 80H..FFH in bank 1
  localparam int          RAM_WORDS      = 288;
  localparam int          RAM_IDX_W      = 9;
  // data memory locations, kept as indices; byte address on the bus is four times these
  localparam logic [7:0]  IDX_PORT0      = 8'h00;
  localparam logic [7:0]  IDX_PTR0       = 8'h01;
  localparam logic [7:0]  IDX_PORT1      = 8'h02;
  localparam logic [7:0]  IDX_PTR1       = 8'h03;
  localparam logic [7:0]  IDX_BANK       = 8'h04;
  localparam logic [7:0]  IDX_ECTL       = 8'h40;
  localparam logic [7:0]  GP0_FIRST      = 8'h60;
  localparam logic [7:0]  GP1_FIRST      = 8'h80;
  localparam int          BANK_BIT       = 0;
  // reset values
  localparam logic [7:0]  PTR_RST        = 8'h00;
  localparam logic        BANK_RST       = 1'b0;
  localparam logic [7:0]  ECTL_RST       = 8'h00;
  // bus
  localparam int          AXI_AW         = 12;
  localparam int          AXI_DW         = 32;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_DECERR    = 2'h3;
  // per-channel handshake state
  typedef enum logic [1:0] {
    CH_IDLE = 2'b01,
    CH_RESP = 2'b10
  } bdma_chan_type;
endpackage : bdma_pkg

// ===== rtl/bdma_gp_ram.sv
// general purpose data storage array for both banks
`timescale 1ns/1ps
module bdma_gp_ram #(
  parameter int WORDS  = bdma_pkg::RAM_WORDS,
  parameter int DATA_W = bdma_pkg::DM_DATA_W,
  parameter int IDX_W  = bdma_pkg::RAM_IDX_W
) (
  input  wire logic              aclk,
  input  wire logic              we,
  input  wire logic [IDX_W-1:0]  waddr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [IDX_W-1:0]  raddr,
  output logic      [DATA_W-1:0] rdata
);
  import bdma_pkg::*;

  // volatile storage: no reset, contents undefined after power up
  logic [DATA_W-1:0] mem [WORDS];

  if (WORDS > (1 << IDX_W) || WORDS < 1) begin : g_chk
    $error("bdma_gp_ram: WORDS does not fit IDX_W");
  end

  // single write port
  always_ff @(posedge aclk) begin
    if (we && (32'(waddr) < WORDS)) begin
      mem[waddr] <= wdata;
    end
  end

  // asynchronous read, out of range reads as zero
  always_comb begin
    rdata = '0;
    if (32'(raddr) < WORDS) begin
      rdata = mem[raddr];
    end
  end
endmodule // bdma_gp_ram

// ===== bench/bdma_cpu_model.sv
// bus master model of the processor core issuing data memory accesses
`timescale 1ns/1ps
module bdma_cpu_model (
  input  wire logic                        aclk,
  output logic [bdma_pkg::AXI_AW-1:0]      awaddr,
  output logic                             awvalid,
  input  wire logic                        awready,
  output logic [bdma_pkg::AXI_DW-1:0]      wdata,
  output logic [3:0]                       wstrb,
  output logic                             wvalid,
  input  wire logic                        wready,
  input  wire logic [1:0]                  bresp,
  input  wire logic                        bvalid,
  output logic                             bready,
  output logic [bdma_pkg::AXI_AW-1:0]      araddr,
  output logic                             arvalid,
  input  wire logic                        arready,
  input  wire logic [bdma_pkg::AXI_DW-1:0] rdata,
  input  wire logic [1:0]                  rresp,
  input  wire logic                        rvalid,
  output logic                             rready
);
  import bdma_pkg::*;
  // idle bus at time zero
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 12'hAAA;
    araddr = 12'h555;
    wdata  = 32'hA5A5A5A5;
    wstrb  = 4'hF;
  end
  // one write: each channel released at the edge that takes it; released lines
  // flip so a stale value never passes for a live one
  task automatic wr(input logic [AXI_AW-1:0] a, input logic [7:0] d, output logic [1:0] resp,
                    input logic [3:0] s = 4'hF);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {24'h000000, d};
    wstrb   <= s;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) begin
        awvalid <= 1'h0;
        awaddr  <= ~a;
      end
      if (wvalid && wready) begin
        wvalid <= 1'h0;
        wdata  <= ~{24'h000000, d};
      end
    end while (bvalid !== 1'h1);
    resp = bresp;
    bready <= 1'h0;
  endtask
  // one read: rready held from the request until the answer is sampled
  task automatic rd(input logic [AXI_AW-1:0] a, output logic [AXI_DW-1:0] d,
                    output logic [1:0] resp);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) begin
        arvalid <= 1'h0;
        araddr  <= ~a;
      end
    end while (rvalid !== 1'h1);
    d = rdata;
    resp = rresp;
    rready <= 1'h0;
  endtask
endmodule // bdma_cpu_model

// ===== bench/tb_top.sv
// self-checking bench for the banked data memory block
`timescale 1ns/1ps
module tb_top;
  import bdma_pkg::*;
  localparam int N_ROWS = 32;
  logic aclk, aresetn, wdt_pd_reset, bank_sel;
  logic [AXI_AW-1:0] awaddr, araddr;
  logic [AXI_DW-1:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] eeprom_ctrl_reg;
  logic [22:0] rows [N_ROWS];
  logic [31:0] rd_val;
  int error_cnt, n_tests, cyc_cnt;

  bdma_core uut (.aclk(aclk), .aresetn(aresetn), .wdt_pd_reset(wdt_pd_reset),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .bank_sel(bank_sel), .eeprom_ctrl_reg(eeprom_ctrl_reg));

  bdma_cpu_model cpu (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  // 200 MHz clock
  initial begin
    aclk = 1'h0;
    forever #2.5 aclk = ~aclk;
  end

  // a hang is cut short well beyond the few hundred cycles the tests need
  always @(posedge aclk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      $display("unexpected cycle_limit expected below 20000 seen %0d", cyc_cnt);
      report_and_stop();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // reset cause held high through every reset edge when asked for
  task automatic do_reset(input logic wdt, input int cyc);
    @(posedge aclk);
    aresetn      <= 1'h0;
    wdt_pd_reset <= wdt;
    repeat (cyc) @(posedge aclk);
    aresetn      <= 1'h1;
    wdt_pd_reset <= 1'h0;
    @(posedge aclk);
  endtask

  // rows: write flag, byte address, data or expected byte, expected response
  initial begin
    rows = '{
      {1'h1, 12'h004, 8'h60, 2'h0}, {1'h0, 12'h004, 8'h60, 2'h0},
      {1'h1, 12'h180, 8'hA5, 2'h0}, {1'h0, 12'h180, 8'hA5, 2'h0},
      {1'h1, 12'h000, 8'h3C, 2'h0}, {1'h0, 12'h180, 8'h3C, 2'h0},
      {1'h0, 12'h000, 8'h3C, 2'h0}, {1'h1, 12'h200, 8'h11, 2'h0},
      {1'h1, 12'h010, 8'hFF, 2'h0}, {1'h0, 12'h010, 8'h01, 2'h0},
      {1'h1, 12'h00C, 8'h80, 2'h0}, {1'h1, 12'h008, 8'h5A, 2'h0},
      {1'h0, 12'h008, 8'h5A, 2'h0}, {1'h0, 12'h200, 8'h11, 2'h0},
      {1'h1, 12'h004, 8'h80, 2'h0}, {1'h0, 12'h000, 8'h11, 2'h0},
      {1'h1, 12'h00C, 8'h40, 2'h0}, {1'h1, 12'h008, 8'h77, 2'h0},
      {1'h0, 12'h008, 8'h77, 2'h0}, {1'h0, 12'h100, 8'h00, 2'h0},
      {1'h1, 12'h004, 8'h02, 2'h0}, {1'h0, 12'h000, 8'h00, 2'h0},
      {1'h1, 12'h000, 8'h99, 2'h0}, {1'h0, 12'h00C, 8'h40, 2'h0},
      {1'h1, 12'h040, 8'hFF, 2'h0}, {1'h0, 12'h040, 8'h00, 2'h0},
      {1'h1, 12'h3FC, 8'hC3, 2'h0}, {1'h0, 12'h3FC, 8'hC3, 2'h0},
      {1'h1, 12'h400, 8'h12, 2'h3}, {1'h0, 12'h400, 8'h00, 2'h3},
      {1'h1, 12'h010, 8'hFE, 2'h0}, {1'h0, 12'h008, 8'h00, 2'h0}
    };
    aresetn      = 1'h0;
    wdt_pd_reset = 1'h0;
    error_cnt    = 0;
    n_tests      = 0;
    cyc_cnt      = 0;
    do_reset(1'h0, 10);
    check("bank_sel", {31'h0, bank_sel}, 32'h0);
    for (int i = 0; i < N_ROWS; i++) begin
      if (rows[i][22]) begin
        cpu.wr(rows[i][21:10], rows[i][9:2], resp);
        check("bresp", {30'h0, resp}, {30'h0, rows[i][1:0]});
      end else begin
        cpu.rd(rows[i][21:10], rd_val, resp);
        check("rdata", rd_val, {24'h000000, rows[i][9:2]});
        check("rresp", {30'h0, resp}, {30'h0, rows[i][1:0]});
      end
    end
    check("eeprom_ctrl_reg", {24'h0, eeprom_ctrl_reg}, 32'h77);
    check("bank_sel", {31'h0, bank_sel}, 32'h0);
    $display("table test done");
    // a write without byte lane 0, and a direct write to the eeprom control location, change nothing
    cpu.wr(12'h180, 8'hEE, resp, 4'h0);
    check("bresp", {30'h0, resp}, {30'h0, RESP_OKAY});
    cpu.rd(12'h180, rd_val, resp);
    check("rdata", rd_val, 32'h3C);
    cpu.wr(12'h100, 8'h55, resp);
    check("eeprom_ctrl_reg", {24'h0, eeprom_ctrl_reg}, 32'h77);
    $display("strobe and direct access test done");
    // watchdog reset in power down keeps bank 1, pointers still clear
    cpu.wr(12'h010, 8'h01, resp);
    do_reset(1'h1, 3);
    check("bank_sel", {31'h0, bank_sel}, 32'h1);
    check("eeprom_ctrl_reg", {24'h0, eeprom_ctrl_reg}, 32'h0);
    cpu.rd(12'h004, rd_val, resp);
    check("rdata", rd_val, 32'h0);
    cpu.rd(12'h010, rd_val, resp);
    check("rdata", rd_val, 32'h1);
    $display("watchdog reset test done");
    // any other reset returns to bank 0
    do_reset(1'h0, 2);
    check("bank_sel", {31'h0, bank_sel}, 32'h0);
    cpu.rd(12'h010, rd_val, resp);
    check("rdata", rd_val, 32'h0);
    $display("plain reset test done");
    report_and_stop();
  end
endmodule // tb_top
